// [hdl/iex_pkg.sv]
// constants, encodings and state type of the instruction exception sequencer
package iex_pkg;
	// opcode patterns: upper half is the mask, lower half the match value
	localparam logic [31:0] IEX_OP_TRAP      = 32'hFF00_C300; // software_trap_op
	localparam logic [31:0] IEX_OP_JUMP      = 32'hF0FF_402B; // jump_op
	localparam logic [31:0] IEX_OP_JSUB      = 32'hF0FF_400B; // jump_subroutine_op
	localparam logic [31:0] IEX_OP_REL       = 32'hF000_A000; // relative_branch_op
	localparam logic [31:0] IEX_OP_BSUB      = 32'hF000_B000; // branch_subroutine_op
	localparam logic [31:0] IEX_OP_RET       = 32'hFFFF_000B; // return op
	localparam logic [31:0] IEX_OP_ERET      = 32'hFFFF_002B; // return_from_exception_op
	localparam logic [31:0] IEX_OP_BTS       = 32'hFF00_8D00; // branch_true_slot_op
	localparam logic [31:0] IEX_OP_BFS       = 32'hFF00_8F00; // branch_false_slot_op
	localparam logic [31:0] IEX_OP_FAR_BR    = 32'hF0FF_0023; // far_branch_op
	localparam logic [31:0] IEX_OP_FAR_CALL  = 32'hF0FF_0003; // far_call_op
	localparam logic [31:0] IEX_OP_BT        = 32'hFF00_8900; // branch true, no slot
	localparam logic [31:0] IEX_OP_BF        = 32'hFF00_8B00; // branch false, no slot
	localparam logic [31:0] IEX_OP_LDCTL_ST  = 32'hF0FF_400E; // load_control_op to status_word
	localparam logic [31:0] IEX_OP_LDCTLM_ST = 32'hF0FF_4007; // load_control_mem_op to status_word
	localparam logic [31:0] IEX_OP_LDCTL     = 32'hF00F_400E; // load_control_op
	localparam logic [31:0] IEX_OP_LDCTLM    = 32'hF00F_4007; // load_control_mem_op
	localparam logic [31:0] IEX_OP_STCTL     = 32'hF00F_0002; // store_control_op
	localparam logic [31:0] IEX_OP_STCTLM    = 32'hF00F_4003; // store_control_mem_op
	localparam logic [31:0] IEX_OP_LDSYS     = 32'hF00F_400A; // load_system_op
	localparam logic [31:0] IEX_OP_LDSYSM    = 32'hF00F_4006; // load_system_mem_op
	localparam logic [31:0] IEX_OP_STSYS     = 32'hF00F_000A; // store_system_op
	localparam logic [31:0] IEX_OP_STSYSM    = 32'hF00F_4002; // store_system_mem_op
	localparam logic [15:0] IEX_UNDEF_LO     = 16'hFC00;      // guaranteed undefined range start
	// vector numbers of the instruction exceptions
	localparam logic [7:0]  IEX_VEC_GEN_ILL  = 8'h04;
	localparam logic [7:0]  IEX_VEC_SLOT_ILL = 8'h06;
	localparam logic [7:0]  IEX_VEC_ADDR_ERR = 8'h09;
	// stack frame geometry
	localparam logic [31:0] IEX_WORD_BYTES   = 32'h0000_0004;
	localparam logic [31:0] IEX_ALIGN_MASK   = 32'hFFFF_FFFC;
	// exception sequence states
	typedef enum logic [2:0] {
		IEX_IDLE,
		IEX_PUSH_SR,
		IEX_PUSH_PC,
		IEX_FETCH_VEC,
		IEX_JUMP
	} iex_state_t;
	// pattern match of an opcode against a mask/match pair
	function automatic logic iex_hit(input logic [15:0] op, input logic [31:0] pat);
		iex_hit = (op & pat[31:16]) == pat[15:0];
	endfunction : iex_hit
endpackage : iex_pkg

// [hdl/iex_classify.sv]
// opcode classifier for the instruction exception sequencer
`timescale 1ns/1ps
`default_nettype none
module iex_classify (
	// decoded opcode
	input  wire logic [15:0] opcode,
	// classification
	output logic             isUndef,
	output logic             isTrap,
	output logic             isDelayed,
	output logic             changesPc,
	output logic             holdsIrq
);
	import iex_pkg::*;
	// pure decode, no state
	always_comb begin
		isUndef   = opcode >= IEX_UNDEF_LO;
		isTrap    = iex_hit(opcode, IEX_OP_TRAP);
		// delayed branch forms
		isDelayed = iex_hit(opcode, IEX_OP_JUMP) | iex_hit(opcode, IEX_OP_JSUB)
			| iex_hit(opcode, IEX_OP_REL) | iex_hit(opcode, IEX_OP_BSUB)
			| iex_hit(opcode, IEX_OP_RET) | iex_hit(opcode, IEX_OP_ERET)
			| iex_hit(opcode, IEX_OP_BTS) | iex_hit(opcode, IEX_OP_BFS)
			| iex_hit(opcode, IEX_OP_FAR_BR) | iex_hit(opcode, IEX_OP_FAR_CALL);
		// anything that rewrites the program_counter, status loads included
		changesPc = isDelayed | isTrap | iex_hit(opcode, IEX_OP_BT)
			| iex_hit(opcode, IEX_OP_BF) | iex_hit(opcode, IEX_OP_LDCTL_ST)
			| iex_hit(opcode, IEX_OP_LDCTLM_ST);
		// control and system register moves hold off interrupts
		holdsIrq  = iex_hit(opcode, IEX_OP_LDCTL) | iex_hit(opcode, IEX_OP_LDCTLM)
			| iex_hit(opcode, IEX_OP_STCTL) | iex_hit(opcode, IEX_OP_STCTLM)
			| iex_hit(opcode, IEX_OP_LDSYS) | iex_hit(opcode, IEX_OP_LDSYSM)
			| iex_hit(opcode, IEX_OP_STSYS) | iex_hit(opcode, IEX_OP_STSYSM);
	end
endmodule : iex_classify
`default_nettype wire

// [hdl/iex_sequencer.sv]
// instruction exception sequencer: acceptance, stacking and vector fetch
`timescale 1ns/1ps
`default_nettype none
module iex_sequencer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// decoder side
	input  wire logic        decValid,
	input  wire logic [15:0] opcode,
	input  wire logic [31:0] instrAddr,
	input  wire logic [31:0] nextAddr,
	input  wire logic [31:0] branchTarget,
	input  wire logic        addrErr,
	// interrupt request from the arbiter
	input  wire logic        irqReq,
	input  wire logic [7:0]  irqVector,
	output logic             irqAck,
	// cpu state
	input  wire logic [31:0] statusWord,
	input  wire logic [31:0] stackPointer,
	input  wire logic [31:0] vectorBase,
	// stack and vector memory bus
	output logic             memReq,
	output logic             memWrite,
	output logic [31:0]      memAddr,
	output logic [31:0]      memWData,
	input  wire logic [31:0] memRData,
	input  wire logic        memAck,
	// results to the pipeline
	output logic             excBusy,
	output logic             pcLoad,
	output logic [31:0]      pcValue,
	output logic [31:0]      spValue
);
	import iex_pkg::*;

	logic       isUndef;   // opcode in undefined range
	logic       isTrap;    // software trap
	logic       isDelayed; // delayed branch
	logic       changesPc; // rewrites program counter
	logic       holdsIrq;  // interrupt-holding instruction

	iex_classify u_classify (
		.opcode    (opcode),
		.isUndef   (isUndef),
		.isTrap    (isTrap),
		.isDelayed (isDelayed),
		.changesPc (changesPc),
		.holdsIrq  (holdsIrq)
	);

	iex_state_t  state, next_state;         // sequence state
	logic        inSlot, next_inSlot;       // next decode is a delay slot
	logic [31:0] slotTarget, next_slotTarget; // target of that branch
	logic [31:0] slotBranch, next_slotBranch; // address of that branch
	logic        holdPrev, next_holdPrev;   // previous decode held interrupts
	logic        irqPend, next_irqPend;     // interrupt seen while blocked
	logic        chainErr, next_chainErr;   // address error seen while stacking
	logic        noAddrErr, next_noAddrErr; // stacking for address error itself
	logic [7:0]  vecNum, next_vecNum;       // vector being served
	logic [31:0] retAddr, next_retAddr;     // address to stack
	logic [31:0] savedSr, next_savedSr;     // status word to stack
	logic [31:0] sp, next_sp;               // working stack pointer
	logic [31:0] handler, next_handler;     // fetched handler address
	logic        next_irqAck;               // interrupt accepted this cycle
	logic        irqAckQ;                   // registered acknowledge
	logic        stackMis;                  // working pointer misaligned
	logic        slotFault;                 // fault in delay slot
	logic        irqOk;                     // interrupt allowed at this decode

	assign stackMis = sp[1:0] != 2'h0;
	// slot faults: undefined, pc-changing, or bus address error there
	assign slotFault = inSlot & (isUndef | changesPc | addrErr);
	// interrupts never inside a slot nor right after a holding instruction
	assign irqOk = (irqReq | irqPend) & !inSlot & !holdPrev;

	// next-state logic for the whole sequencer
	always_comb begin
		next_state      = state;
		next_inSlot     = inSlot;
		next_slotTarget = slotTarget;
		next_slotBranch = slotBranch;
		next_holdPrev   = holdPrev;
		next_irqPend    = irqPend;
		next_chainErr   = chainErr;
		next_noAddrErr  = noAddrErr;
		next_vecNum     = vecNum;
		next_retAddr    = retAddr;
		next_savedSr    = savedSr;
		next_sp         = sp;
		next_handler    = handler;
		next_irqAck     = 1'b0;
		case (state)
			IEX_IDLE: begin
				if (decValid) begin
					next_inSlot     = isDelayed;
					next_slotTarget = branchTarget;
					next_slotBranch = instrAddr;
					next_holdPrev   = holdsIrq;
					// blocked interrupt stays held for the next permitting decode
					next_irqPend    = irqPend | irqReq;
					next_savedSr    = statusWord;
					next_sp         = stackPointer;
					next_noAddrErr  = 1'b0;
					if (slotFault) begin
						// address error stacks the branch address, other slot faults stack its target
						next_state   = IEX_PUSH_SR;
						next_vecNum  = addrErr ? IEX_VEC_ADDR_ERR : IEX_VEC_SLOT_ILL;
						next_retAddr = addrErr ? slotBranch : slotTarget;
					end else if (!inSlot && addrErr) begin
						next_state   = IEX_PUSH_SR;
						next_vecNum  = IEX_VEC_ADDR_ERR;
						next_retAddr = instrAddr;
					end else if (!inSlot && isUndef) begin
						next_state   = IEX_PUSH_SR;
						next_vecNum  = IEX_VEC_GEN_ILL;
						next_retAddr = instrAddr;
					end else if (!inSlot && isTrap) begin
						next_state   = IEX_PUSH_SR;
						next_vecNum  = opcode[7:0];
						next_retAddr = nextAddr;
					end else if (irqOk) begin
						// decoded instruction is replaced; it runs after return
						next_state   = IEX_PUSH_SR;
						next_vecNum  = irqVector;
						next_retAddr = instrAddr;
						next_irqPend = 1'b0;
						next_irqAck  = 1'b1;
					end
					if (next_state != IEX_IDLE) begin
						next_inSlot   = 1'b0;
						next_holdPrev = 1'b0;
					end
				end
			end
			IEX_PUSH_SR: begin
				// status word first, one word below the entry pointer
				if (memAck) begin
					next_sp = sp - IEX_WORD_BYTES;
					if (stackMis && !noAddrErr) begin
						next_chainErr = 1'b1;
					end
					next_state = IEX_PUSH_PC;
				end
			end
			IEX_PUSH_PC: begin
				// return address ends at the final pointer
				if (memAck) begin
					next_sp    = sp - IEX_WORD_BYTES;
					next_state = IEX_FETCH_VEC;
				end
			end
			IEX_FETCH_VEC: begin
				if (memAck) begin
					next_handler = memRData;
					next_state   = IEX_JUMP;
				end
			end
			IEX_JUMP: begin
				// non-delayed branch to the handler, then any chained error
				if (chainErr) begin
					next_state     = IEX_PUSH_SR;
					next_chainErr  = 1'b0;
					next_noAddrErr = 1'b1;
					next_vecNum    = IEX_VEC_ADDR_ERR;
					next_retAddr   = handler;
				end else begin
					next_state     = IEX_IDLE;
				end
			end
			default: begin
				next_state = IEX_IDLE;
			end
		endcase
	end

	// state registers; reset drops any held interrupt
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= IEX_IDLE;
			inSlot     <= 1'b0;
			slotTarget <= 32'h0000_0000;
			slotBranch <= 32'h0000_0000;
			holdPrev   <= 1'b0;
			irqPend    <= 1'b0;
			chainErr   <= 1'b0;
			noAddrErr  <= 1'b0;
			vecNum     <= 8'h00;
			retAddr    <= 32'h0000_0000;
			savedSr    <= 32'h0000_0000;
			sp         <= 32'h0000_0000;
			handler    <= 32'h0000_0000;
			irqAckQ    <= 1'b0;
		end else begin
			state      <= next_state;
			inSlot     <= next_inSlot;
			slotTarget <= next_slotTarget;
			slotBranch <= next_slotBranch;
			holdPrev   <= next_holdPrev;
			irqPend    <= next_irqPend;
			chainErr   <= next_chainErr;
			noAddrErr  <= next_noAddrErr;
			vecNum     <= next_vecNum;
			retAddr    <= next_retAddr;
			savedSr    <= next_savedSr;
			sp         <= next_sp;
			handler    <= next_handler;
			irqAckQ    <= next_irqAck;
		end
	end

	// bus drive; the write happens even on a misaligned pointer
	always_comb begin
		memReq   = state == IEX_PUSH_SR || state == IEX_PUSH_PC || state == IEX_FETCH_VEC;
		memWrite = state == IEX_PUSH_SR || state == IEX_PUSH_PC;
		memWData = state == IEX_PUSH_SR ? savedSr : retAddr;
		if (state == IEX_FETCH_VEC) begin
			memAddr = vectorBase + {22'h0, vecNum, 2'h0};
		end else begin
			memAddr = (sp - IEX_WORD_BYTES) & IEX_ALIGN_MASK;
		end
	end

	assign excBusy = state != IEX_IDLE;
	assign pcLoad  = state == IEX_JUMP;
	assign pcValue = handler;
	assign spValue = sp;
	assign irqAck  = irqAckQ;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_trap_return: assert property (decValid && !excBusy && !inSlot && isTrap
		&& !addrErr && !isUndef |=> ##1 memWData == $past(nextAddr, 2) || state == IEX_PUSH_SR)
		else $error("trap return address wrong");
	a_trap_vector: assert property (decValid && !excBusy && !inSlot && isTrap
		&& !addrErr |=> vecNum == $past(opcode[7:0]))
		else $error("trap vector number wrong");
	a_slot_take: assert property (decValid && !excBusy && inSlot && (isUndef || changesPc)
		&& !addrErr |=> state == IEX_PUSH_SR && vecNum == IEX_VEC_SLOT_ILL
		&& retAddr == $past(slotTarget))
		else $error("slot exception not taken");
	a_gen_illegal: assert property (decValid && !excBusy && !inSlot && isUndef
		&& !addrErr |=> retAddr == $past(instrAddr) && vecNum == IEX_VEC_GEN_ILL)
		else $error("general illegal frame wrong");
	a_irq_slot: assert property (inSlot |-> !next_irqAck)
		else $error("interrupt taken in slot");
	a_irq_hold: assert property (holdPrev |-> !next_irqAck)
		else $error("interrupt taken after holder");
	a_frame_order: assert property (state == IEX_PUSH_SR && memAck |=>
		state == IEX_PUSH_PC && memAddr == (($past(sp) - 32'h0000_0008) & IEX_ALIGN_MASK))
		else $error("frame layout wrong");
	a_align_addr: assert property (memReq && memWrite |-> memAddr[1:0] == 2'h0)
		else $error("stack address not aligned");
	a_chain_once: assert property (state == IEX_JUMP && noAddrErr |=> state == IEX_IDLE)
		else $error("address error chained twice");
	a_pend_kept: assert property (decValid && !excBusy && irqReq && (inSlot || holdPrev)
		&& !slotFault && !addrErr && !isUndef && !isTrap |=> irqPend)
		else $error("blocked interrupt lost");

	c_trap:  cover property (state == IEX_PUSH_SR && vecNum != IEX_VEC_SLOT_ILL ##[1:20] pcLoad);
	c_slot:  cover property (slotFault && decValid && !excBusy);
	c_irq:   cover property (irqAck);
	c_chain: cover property (pcLoad && chainErr);
endmodule : iex_sequencer
`default_nettype wire

// [test/iex_mem_model.sv]
// behavioural stack and vector-table memory on the sequencer's bus
`timescale 1ns/1ps
`default_nettype none
module iex_mem_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// bus from the sequencer
	input  wire logic        memReq,
	input  wire logic        memWrite,
	input  wire logic [31:0] memAddr,
	// wait states before each acknowledge
	input  wire logic [1:0]  waitCyc,
	// answer
	output logic [31:0]      memRData,
	output logic             memAck
);
	logic [1:0] waited; // cycles spent on the current access
	// count wait states, restart after each completed access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			waited <= 2'h0;
		end else if (memAck) begin
			waited <= 2'h0;
		end else if (memReq) begin
			waited <= waited + 2'h1;
		end
	end
	// ack only while a request stands; zero waits answers at once
	assign memAck = memReq && (waited == waitCyc);
	// handler is entry address plus an offset; scrambled when not answering
	assign memRData = (memAck && !memWrite) ? memAddr + 32'h0001_0000 : ~memAddr;
endmodule : iex_mem_model
`default_nettype wire

// [test/iex_sequencer_tb.sv]
// self-checking bench of the instruction exception sequencer
`timescale 1ns/1ps
`default_nettype none
module iex_sequencer_tb;
	import iex_pkg::*;
	// bench-driven inputs
	logic        clk, arst_n, decValid, addrErr, irqReq;
	logic [15:0] opcode;
	logic [31:0] instrAddr, nextAddr, branchTarget;
	logic [31:0] statusWord, stackPointer, vectorBase;
	logic [7:0]  irqVector;
	logic [1:0]  waitCyc;
	// design outputs and memory answer
	logic        irqAck, memReq, memWrite, memAck, excBusy, pcLoad;
	logic [31:0] memAddr, memWData, memRData, pcValue, spValue;
	// captured transfers and branches
	logic [31:0] ad [8], da [8], pv [4], sv [4];
	logic        wr [8];
	int          nx, np, nAck, n_fail, tests_run;

	iex_sequencer uut (.clk, .arst_n, .decValid, .opcode, .instrAddr, .nextAddr,
		.branchTarget, .addrErr, .irqReq, .irqVector, .irqAck, .statusWord,
		.stackPointer, .vectorBase, .memReq, .memWrite, .memAddr, .memWData,
		.memRData, .memAck, .excBusy, .pcLoad, .pcValue, .spValue);
	iex_mem_model mem (.clk, .arst_n, .memReq, .memWrite, .memAddr, .waitCyc,
		.memRData, .memAck);

	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// comb outputs are settled at the falling edge, so capture there
	always @(negedge clk) begin
		if (memReq === 1'b1 && memAck === 1'b1 && nx < 8) begin
			ad[nx] = memAddr;
			da[nx] = memWData;
			wr[nx] = memWrite;
			nx++;
		end
		if (pcLoad === 1'b1 && np < 4) begin
			pv[np] = pcValue;
			sv[np] = spValue;
			np++;
		end
		if (irqAck === 1'b1)
			nAck++;
	end
	// one compare for every 32-bit result
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// fresh capture, wait states and stack pointer for one sequence
	task automatic start(input logic [1:0] w, input logic [31:0] sp);
		nx = 0;
		np = 0;
		nAck = 0;
		waitCyc = w;
		stackPointer = sp;
		statusWord = statusWord + 32'h0000_0011;
	endtask : start
	// one decode per edge; valid stays up so decodes run back to back
	task automatic dec(input logic [15:0] op, input logic [31:0] ia, input logic ae);
		@(posedge clk);
		#2;
		decValid = 1'b1;
		opcode = op;
		instrAddr = ia;
		nextAddr = ia + 32'h0000_0002;
		branchTarget = ia + 32'h0000_0100;
		addrErr = ae;
	endtask : dec
	task automatic idle();
		@(posedge clk);
		#2;
		decValid = 1'b0;
		addrErr = 1'b0;
	endtask : idle
	// bounded wait for n branches and the end of the sequence
	task automatic wait_pc(input int n);
		int i;
		// look off the edge so the flags read are settled
		for (i = 0; i < 300 && (np < n || excBusy !== 1'b0); i++) begin
			@(posedge clk);
			#2;
		end
		if (i == 300) begin
			n_fail++;
			end_sim();
		end
	endtask : wait_pc
	// one stacked frame from transfer b and branch p
	task automatic frame(input int b, input int p, input logic [31:0] sp,
		input logic [31:0] ret, input logic [7:0] vec);
		logic [31:0] va;
		va = vectorBase + {22'h0, vec, 2'h0};
		chk("push1 addr", (sp - 32'h4) & 32'hFFFF_FFFC, ad[b]);
		chk("push1 data", statusWord, da[b]);
		chk("push2 addr", (sp - 32'h8) & 32'hFFFF_FFFC, ad[b+1]);
		chk("push2 data", ret, da[b+1]);
		chk("kinds", 32'h6, {29'h0, wr[b], wr[b+1], wr[b+2]});
		chk("vector addr", va, ad[b+2]);
		chk("handler", va + 32'h0001_0000, pv[p]);
		chk("final sp", sp - 32'h8, sv[p]);
	endtask : frame

	task automatic t_trap();
		start(2'h0, 32'h0000_2000);
		dec(16'hC321, 32'h0000_0400, 1'b0);
		idle();
		wait_pc(1);
		frame(0, 0, 32'h0000_2000, 32'h0000_0402, 8'h21);
		$display("test trap finished");
	endtask : t_trap
	// every delayed branch with a faulting slot op; return-from-exception slot left out
	task automatic t_slot();
		logic [15:0] br [9] = '{16'h412B, 16'h410B, 16'hA123, 16'hB456, 16'h000B,
			16'h8D10, 16'h8F10, 16'h0123, 16'h0103};
		logic [15:0] sl [6] = '{16'hFC05, 16'h412B, 16'h8900, 16'hC310, 16'h410E,
			16'h4107};
		for (int i = 0; i < 9; i++) begin
			start(i[1:0], 32'h0000_3000);
			dec(br[i], 32'h0000_0500, 1'b0);
			dec(sl[i % 6], 32'h0000_0502, 1'b0);
			idle();
			wait_pc(1);
			frame(0, 0, 32'h0000_3000, 32'h0000_0600, IEX_VEC_SLOT_ILL);
		end
		$display("test slot illegal finished");
	endtask : t_slot
	// undefined at both range ends, right after a holding op
	task automatic t_gen();
		for (int j = 0; j < 2; j++) begin
			start(2'h1, 32'h0000_2100);
			dec(16'h4002, 32'h0000_0700, 1'b0);
			dec(j == 0 ? 16'hFC00 : 16'hFFFF, 32'h0000_0702, 1'b0);
			idle();
			wait_pc(1);
			frame(0, 0, 32'h0000_2100, 32'h0000_0702, IEX_VEC_GEN_ILL);
		end
		$display("test general illegal finished");
	endtask : t_gen
	// request after each holding op waits one instruction, kept when dropped
	task automatic t_hold();
		logic [15:0] ho [8] = '{16'h401E, 16'h4017, 16'h0012, 16'h4013, 16'h400A,
			16'h4006, 16'h000A, 16'h4002};
		for (int k = 0; k < 8; k++) begin
			start(k[1:0], 32'h0000_2200);
			irqVector = 8'h40 + k[7:0];
			dec(ho[k], 32'h0000_0800, 1'b0);
			dec(16'h0009, 32'h0000_0802, 1'b0);
			irqReq = 1'b1;
			dec(16'h0009, 32'h0000_0804, 1'b0);
			irqReq = 1'b0;
			idle();
			wait_pc(1);
			frame(0, 0, 32'h0000_2200, 32'h0000_0804, irqVector);
			chk("irq acks", 32'h1, nAck);
		end
		$display("test holding finished");
	endtask : t_hold
	// request seen in a slot is taken at the branch destination
	task automatic t_irqslot();
		start(2'h3, 32'h0000_2300);
		irqVector = 8'h50;
		dec(16'hA010, 32'h0000_0900, 1'b0);
		dec(16'h0009, 32'h0000_0902, 1'b0);
		irqReq = 1'b1;
		dec(16'h0009, 32'h0000_0A00, 1'b0);
		irqReq = 1'b0;
		idle();
		wait_pc(1);
		frame(0, 0, 32'h0000_2300, 32'h0000_0A00, 8'h50);
		$display("test slot interrupt finished");
	endtask : t_irqslot
	// address error in a slot stacks the branch address
	task automatic t_slotae();
		start(2'h0, 32'h0000_2400);
		dec(16'hA010, 32'h0000_0B00, 1'b0);
		dec(16'h0009, 32'h0000_0B02, 1'b1);
		idle();
		wait_pc(1);
		frame(0, 0, 32'h0000_2400, 32'h0000_0B00, IEX_VEC_ADDR_ERR);
		// outside a slot, right after a holder, the error is taken at once
		start(2'h1, 32'h0000_2400);
		dec(16'h400A, 32'h0000_0B10, 1'b0);
		dec(16'h0009, 32'h0000_0B12, 1'b1);
		idle();
		wait_pc(1);
		frame(0, 0, 32'h0000_2400, 32'h0000_0B12, IEX_VEC_ADDR_ERR);
		$display("test slot address error finished");
	endtask : t_slotae
	// misaligned stack: frame, one chained error frame, then nothing more
	task automatic t_misal();
		start(2'h2, 32'h0000_1002);
		dec(16'hC322, 32'h0000_0C00, 1'b0);
		idle();
		wait_pc(2);
		frame(0, 0, 32'h0000_1002, 32'h0000_0C02, 8'h22);
		frame(3, 1, 32'h0000_0FFA, pv[0], IEX_VEC_ADDR_ERR);
		chk("transfers", 32'h6, nx);
		$display("test misaligned stack finished");
	endtask : t_misal
	// a held request does not survive reset
	task automatic t_reset();
		start(2'h0, 32'h0000_2500);
		dec(16'h401E, 32'h0000_0D00, 1'b0);
		dec(16'h0009, 32'h0000_0D02, 1'b0);
		irqReq = 1'b1;
		idle();
		irqReq = 1'b0;
		arst_n = 1'b0;
		#5;
		chk("reset outs", 32'h0, {28'h0, excBusy, memReq, pcLoad, irqAck});
		chk("reset addr", 32'hFFFF_FFFC, memAddr);
		idle();
		arst_n = 1'b1;
		dec(16'h0009, 32'h0000_0D10, 1'b0);
		idle();
		repeat (3) @(posedge clk);
		chk("no exception", 32'h0, {nx[7:0], nAck[7:0], 15'h0, excBusy});
		$display("test reset finished");
	endtask : t_reset

	initial begin
		{arst_n, decValid, addrErr, irqReq, opcode, irqVector, waitCyc} = '0;
		{instrAddr, nextAddr, branchTarget, statusWord, stackPointer} = '0;
		vectorBase = 32'h0000_4000;
		{nx, np, nAck, n_fail, tests_run} = '0;
		repeat (20) @(posedge clk);
		#2;
		arst_n = 1'b1;
		t_trap();
		t_slot();
		t_gen();
		t_hold();
		t_irqslot();
		t_slotae();
		t_misal();
		t_reset();
		end_sim();
	end
endmodule : iex_sequencer_tb
`default_nettype wire
